// ==== rtl/sscrm_regmap.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Four ranges decode: 0x00-0x02, 0x05 and 0xFF, 0x08-0x18, 0x100-0x123.
// - Every register location holds one byte with bit 7 as its MSB.
// - The reference select at 0x18 resets to 0xC0.
// - The i_srst input reloads the critical registers with their defaults; a soft reset write does not.
// - 0x08-0x18 and 0x11E-0x123 are shadowed until a transfer.
// - Writing 0x01 to 0xFF copies every shadow into the active set.
// - The transfer bit clears itself after the update.
// - Local registers exist per channel, chosen by the bits in 0x05.
// - With both channel bits set a local write updates both copies.
// - With both channel bits set a local read returns channel A.
// - Global registers behave the same whatever 0x05 holds.
// - A frame is a 16-bit instruction followed by 8-bit data words.
// - Bits shift MSB first until the port setup selects LSB first.
module sscrm_regmap #(
  parameter logic [7:0] CHIP_ID = 8'h5A,   // Arbitrary identity value.
  parameter logic [7:0] CHIP_GRADE = 8'h00 // Arbitrary grade value.
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdio,
  output logic o_spi_sdio,
  output logic o_spi_sdio_oe,
  output sscrm_pkg::sscrm_chan_cfg_type o_active_a,
  output sscrm_pkg::sscrm_chan_cfg_type o_active_b
);

  logic sclk_s, cs_n_s, sdio_s, sclk_q_r, rise, fall, lsb_first;
  sscrm_pkg::sscrm_state_type st_r;
  sscrm_pkg::sscrm_instr_type instr_r, instr_nxt;
  logic [15:0] shift_r, shift_nxt, shift_rev;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [12:0] addr_nxt, conv_off, feat_off;
  logic [7:0] port_cfg_r, chan_sel_r, wr_byte, rd_byte, byte_rev;
  logic xfer_r, wr_stb, rd_ch, in_conv, in_feat;
  logic [2:0] bit_sel;
  logic [4:0] conv_idx;
  logic [5:0] feat_idx;
  sscrm_pkg::sscrm_chan_cfg_type sh_r [2];
  sscrm_pkg::sscrm_chan_cfg_type act_r [2];

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  sscrm_pin_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_pin(i_spi_sclk), .o_level(sclk_s)
  );
  sscrm_pin_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_pin(i_spi_cs_n), .o_level(cs_n_s)
  );
  sscrm_pin_sync #(.RST_VAL(1'b0)) u_sync_sdio (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_pin(i_spi_sdio), .o_level(sdio_s)
  );

  // Previous serial clock level for edge detection.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= sclk_s;
    end
  end

  // Edges count only while the chip select is low.
  assign rise = sclk_s & ~sclk_q_r & ~cs_n_s;
  assign fall = ~sclk_s & sclk_q_r & ~cs_n_s;
  assign lsb_first = port_cfg_r[sscrm_pkg::PORT_LSB_HI] |
                     port_cfg_r[sscrm_pkg::PORT_LSB_LO];

  // ----------------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------------
  // Received bits land at the bottom; LSB-first order is undone by reversal.
  assign shift_nxt = {shift_r[14:0], sdio_s};
  assign shift_rev = {<<{shift_nxt}};
  assign byte_rev = {<<{shift_nxt[7:0]}};
  assign instr_nxt = lsb_first ? shift_rev : shift_nxt;
  assign wr_byte = lsb_first ? byte_rev : shift_nxt[7:0];
  assign addr_nxt = lsb_first ? instr_r.addr + sscrm_pkg::ADDR_STEP
                              : instr_r.addr - sscrm_pkg::ADDR_STEP;
  assign wr_stb = rise & (st_r == sscrm_pkg::ST_DATA) & ~instr_r.rd &
                  (bit_cnt_r[2:0] == sscrm_pkg::BYTE_LAST);

  // Sixteen instruction bits, then bytes until the length is used up.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || cs_n_s) begin
      st_r <= sscrm_pkg::ST_INSTR;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
      shift_r <= '0;
      if (i_srst) begin
        instr_r <= '0;
      end
    end else if (rise) begin
      unique case (st_r)
        sscrm_pkg::ST_INSTR: begin
          shift_r <= shift_nxt;
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == sscrm_pkg::INSTR_LAST) begin
            instr_r <= instr_nxt;
            st_r <= sscrm_pkg::ST_DATA;
            bit_cnt_r <= '0;
            byte_cnt_r <= '0;
          end
        end
        sscrm_pkg::ST_DATA: begin
          shift_r <= shift_nxt;
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r[2:0] == sscrm_pkg::BYTE_LAST) begin
            bit_cnt_r <= '0;
            instr_r.addr <= addr_nxt;
            byte_cnt_r <= byte_cnt_r + 2'h1;
            if (instr_r.len != sscrm_pkg::LEN_STREAM &&
                byte_cnt_r == instr_r.len) begin
              st_r <= sscrm_pkg::ST_DONE;
            end
          end
        end
        sscrm_pkg::ST_DONE: begin
          st_r <= sscrm_pkg::ST_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Address decode and readback
  // ----------------------------------------------------------------------
  assign conv_off = instr_r.addr - sscrm_pkg::ADDR_CONV_LO;
  assign feat_off = instr_r.addr - sscrm_pkg::ADDR_FEAT_LO;
  assign conv_idx = conv_off[4:0];
  assign feat_idx = feat_off[5:0];
  assign in_conv = instr_r.addr >= sscrm_pkg::ADDR_CONV_LO &&
                   instr_r.addr <= sscrm_pkg::ADDR_CONV_HI;
  assign in_feat = instr_r.addr >= sscrm_pkg::ADDR_FEAT_LO &&
                   instr_r.addr <= sscrm_pkg::ADDR_FEAT_HI;
  // Channel A wins unless only channel B is selected.
  assign rd_ch = chan_sel_r[1] & ~chan_sel_r[0];

  // Reads show the shadow copy, so a write is visible before any transfer.
  always_comb begin
    rd_byte = sscrm_pkg::BYTE_ZERO;
    if (instr_r.addr == sscrm_pkg::ADDR_PORT_CFG) begin
      rd_byte = port_cfg_r;
    end else if (instr_r.addr == sscrm_pkg::ADDR_CHIP_ID) begin
      rd_byte = CHIP_ID;
    end else if (instr_r.addr == sscrm_pkg::ADDR_CHIP_GRADE) begin
      rd_byte = CHIP_GRADE;
    end else if (instr_r.addr == sscrm_pkg::ADDR_CHAN_SEL) begin
      rd_byte = chan_sel_r;
    end else if (instr_r.addr == sscrm_pkg::ADDR_XFER) begin
      rd_byte = {7'h00, xfer_r};
    end else if (in_conv) begin
      rd_byte = sh_r[rd_ch].conv[conv_idx];
    end else if (in_feat) begin
      rd_byte = sh_r[rd_ch].feat[feat_idx];
    end
  end

  // Read data changes on the falling serial edge, ready for the next rise.
  assign bit_sel = lsb_first ? bit_cnt_r[2:0]
                             : sscrm_pkg::BYTE_LAST - bit_cnt_r[2:0];
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || cs_n_s) begin
      o_spi_sdio <= 1'b0;
      o_spi_sdio_oe <= 1'b0;
    end else if (fall && st_r == sscrm_pkg::ST_DATA && instr_r.rd) begin
      o_spi_sdio <= rd_byte[bit_sel];
      o_spi_sdio_oe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------------
  // Soft reset bits are not kept and the fixed ones always read as set.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      port_cfg_r <= sscrm_pkg::PORT_CFG_RST;
    end else if (wr_stb && instr_r.addr == sscrm_pkg::ADDR_PORT_CFG) begin
      port_cfg_r <= (wr_byte & sscrm_pkg::PORT_CFG_KEEP) |
                    sscrm_pkg::PORT_CFG_FIXED;
    end
  end

  // Channel select bits steer local accesses only.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      chan_sel_r <= sscrm_pkg::CHAN_SEL_RST;
    end else if (wr_stb && instr_r.addr == sscrm_pkg::ADDR_CHAN_SEL) begin
      chan_sel_r <= wr_byte & sscrm_pkg::CHAN_SEL_MASK;
    end
  end

  // Transfer command lasts one cycle; a new command wins over the clear.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      xfer_r <= 1'b0;
    end else if (wr_stb && instr_r.addr == sscrm_pkg::ADDR_XFER &&
                 wr_byte == sscrm_pkg::XFER_CMD) begin
      xfer_r <= 1'b1;
    end else begin
      xfer_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel shadow and active banks
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    // Writes reach every channel whose select bit is set.
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        sh_r[c] <= '0;
        sh_r[c].conv[sscrm_pkg::VREF_IDX] <= sscrm_pkg::VREF_RST;
      end else if (wr_stb && chan_sel_r[c]) begin
        if (in_conv) begin
          sh_r[c].conv[conv_idx] <= wr_byte;
        end else if (in_feat) begin
          sh_r[c].feat[feat_idx] <= wr_byte;
        end
      end
    end

    // Unshadowed feature bytes act at once; the rest wait for a transfer.
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        act_r[c] <= '0;
        act_r[c].conv[sscrm_pkg::VREF_IDX] <= sscrm_pkg::VREF_RST;
      end else if (xfer_r) begin
        act_r[c].conv <= sh_r[c].conv;
        act_r[c].feat[sscrm_pkg::FEAT_N-1:sscrm_pkg::FEAT_SHADOW_BASE] <=
          sh_r[c].feat[sscrm_pkg::FEAT_N-1:sscrm_pkg::FEAT_SHADOW_BASE];
      end else if (wr_stb && chan_sel_r[c] && in_feat &&
                   feat_idx < sscrm_pkg::FEAT_SHADOW_IDX) begin
        act_r[c].feat[feat_idx] <= wr_byte;
      end
    end
  end

  assign o_active_a = act_r[0];
  assign o_active_b = act_r[1];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // The end of the instruction and the one-cycle transfer pulse.
  sequence s_instr_end;
    rise && st_r == sscrm_pkg::ST_INSTR && bit_cnt_r == sscrm_pkg::INSTR_LAST;
  endsequence
  sequence s_xfer_pulse;
    xfer_r ##1 !xfer_r;
  endsequence
  property p_vref_reset;
    $fell(i_srst) |->
      act_r[0].conv[sscrm_pkg::VREF_IDX] == sscrm_pkg::VREF_RST &&
      sh_r[1].conv[sscrm_pkg::VREF_IDX] == sscrm_pkg::VREF_RST &&
      port_cfg_r == sscrm_pkg::PORT_CFG_RST;
  endproperty
  a_vref_reset: assert property (p_vref_reset)
    else $error("Reset defaults not loaded.");
  property p_instr_len;
    s_instr_end |=> st_r == sscrm_pkg::ST_DATA && bit_cnt_r == 4'h0;
  endproperty
  a_instr_len: assert property (p_instr_len)
    else $error("Instruction phase did not end after 16 bits.");
  property p_xfer_copy;
    xfer_r |=> act_r[0].conv == $past(sh_r[0].conv) &&
      act_r[1].conv == $past(sh_r[1].conv) && !xfer_r;
  endproperty
  a_xfer_copy: assert property (p_xfer_copy)
    else $error("Transfer did not copy shadows or did not clear.");
  property p_shadow_hold;
    !xfer_r |=> $stable(act_r[0].conv) && $stable(act_r[1].conv);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("Active converter bank changed without a transfer.");
  property p_xfer_cmd;
    wr_stb && instr_r.addr == sscrm_pkg::ADDR_XFER &&
      wr_byte == sscrm_pkg::XFER_CMD |=> s_xfer_pulse;
  endproperty
  a_xfer_cmd: assert property (p_xfer_cmd)
    else $error("Transfer bit did not pulse for one cycle.");
  property p_both_write;
    wr_stb && in_conv && chan_sel_r[1:0] == 2'b11 |=>
      sh_r[0].conv[$past(conv_idx)] == $past(wr_byte) &&
      sh_r[1].conv[$past(conv_idx)] == $past(wr_byte);
  endproperty
  a_both_write: assert property (p_both_write)
    else $error("Dual-channel write missed a copy.");
  property p_one_chan;
    wr_stb && chan_sel_r[1:0] == 2'b01 |=> $stable(sh_r[1]);
  endproperty
  a_one_chan: assert property (p_one_chan)
    else $error("Channel B copy changed while only A selected.");
  property p_read_a;
    in_conv && chan_sel_r[0] |-> rd_byte == sh_r[0].conv[conv_idx];
  endproperty
  a_read_a: assert property (p_read_a)
    else $error("Local read did not return the channel A copy.");
  property p_global;
    instr_r.addr == sscrm_pkg::ADDR_PORT_CFG |-> rd_byte == port_cfg_r;
  endproperty
  a_global: assert property (p_global)
    else $error("Global read depends on channel select.");
  property p_unmapped;
    instr_r.addr == 13'h0003 || instr_r.addr == 13'h0124 |->
      rd_byte == sscrm_pkg::BYTE_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unsupported location did not read as zero.");
  property p_msb_out;
    fall && st_r == sscrm_pkg::ST_DATA && instr_r.rd && !lsb_first |=>
      o_spi_sdio == $past(rd_byte[sscrm_pkg::BYTE_LAST - bit_cnt_r[2:0]]) &&
      o_spi_sdio_oe;
  endproperty
  a_msb_out: assert property (p_msb_out)
    else $error("Read bit not shifted MSB first.");

endmodule // sscrm_regmap

// ==== rtl/sscrm_pkg.sv ====
package sscrm_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_ID = 13'h0001;
  localparam logic [12:0] ADDR_CHIP_GRADE = 13'h0002;
  localparam logic [12:0] ADDR_CHAN_SEL = 13'h0005;
  localparam logic [12:0] ADDR_CONV_LO = 13'h0008;
  localparam logic [12:0] ADDR_CONV_HI = 13'h0018;
  localparam logic [12:0] ADDR_XFER = 13'h00FF;
  localparam logic [12:0] ADDR_FEAT_LO = 13'h0100;
  localparam logic [12:0] ADDR_FEAT_HI = 13'h0123;
  localparam logic [12:0] ADDR_STEP = 13'h0001;

  // ----------------------------------------------------------------------
  // Bank sizes and field positions
  // ----------------------------------------------------------------------
  localparam int CONV_N = 17;
  localparam int FEAT_N = 36;
  localparam int FEAT_SHADOW_BASE = 30;
  localparam logic [5:0] FEAT_SHADOW_IDX = 6'h1E;
  localparam logic [4:0] VREF_IDX = 5'h10;
  localparam int PORT_LSB_HI = 6;
  localparam int PORT_LSB_LO = 1;

  // ----------------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] VREF_RST = 8'hC0;
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] PORT_CFG_KEEP = 8'h42;
  localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
  localparam logic [7:0] CHAN_SEL_RST = 8'h03;
  localparam logic [7:0] CHAN_SEL_MASK = 8'h03;
  localparam logic [7:0] XFER_CMD = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Serial framing counts
  // ----------------------------------------------------------------------
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic [1:0] len;
    logic [12:0] addr;
  } sscrm_instr_type;

  typedef struct packed {
    logic [FEAT_N-1:0][7:0] feat;
    logic [CONV_N-1:0][7:0] conv;
  } sscrm_chan_cfg_type;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA = 2'b01,
    ST_DONE = 2'b11
  } sscrm_state_type;

endpackage

// ==== rtl/sscrm_pin_sync.sv ====
`timescale 1ns/1ps
// Three-stage pin synchroniser; the output follows once stages two and
// three agree, which filters a single-cycle glitch after metastability.
module sscrm_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  output logic o_level
);

  logic meta_r;
  logic s2_r;
  logic s3_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      meta_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      o_level <= RST_VAL;
    end else begin
      meta_r <= i_pin;
      s2_r <= meta_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end

endmodule // sscrm_pin_sync

// ==== tb/sscrm_host_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------------
// Serial host model
// ------------------------------------------------------------------------
// Behavioural host controller. Clock idles low, data changes while the
// clock is low and is sampled on the rise. Each half period lasts 8 ref
// clocks, which is above the 5 the synchronisers need.
module sscrm_host_model (
  input wire logic i_ref_clk,
  input wire logic i_sdio,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdio,
  output logic o_sdio_oe
);
  localparam int HALF = 8;
  logic lsb_first;

  // Idle pins at time zero.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdio = 1'b0;
    o_sdio_oe = 1'b0;
    lsb_first = 1'b0;
  end

  // Inputs of the block move on the falling ref clock edge only.
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // One bit slot. A released line toggles so that a stale bit never
  // passes for read data.
  task automatic bit_slot(input logic drv, input logic val,
                          output logic got);
    o_sdio_oe = drv;
    o_sdio = drv ? val : ~o_sdio;
    wait_clk(HALF);
    got = i_sdio;
    o_sclk = 1'b1;
    wait_clk(HALF);
    o_sclk = 1'b0;
  endtask

  // A whole frame: instruction, then len+1 bytes, left aligned in data.
  // Stream mode sends three bytes, then chip select high ends it.
  task automatic frame(input logic rd, input logic [1:0] len,
                       input logic [12:0] addr, input logic [23:0] wdata,
                       output logic [23:0] rdata);
    logic [15:0] ins;
    logic [7:0] b;
    logic got;
    int n;
    ins = {rd, len, addr};
    rdata = 24'h000000;
    n = (len == 2'h3) ? 3 : int'(len) + 1;
    o_cs_n = 1'b0;
    wait_clk(HALF);
    for (int i = 0; i < 16; i++) begin
      bit_slot(1'b1, lsb_first ? ins[i] : ins[15-i], got);
    end
    for (int k = 0; k < n; k++) begin
      // Whole bytes are sent, unused bits held at zero.
      b = wdata[23-8*k -: 8];
      for (int i = 0; i < 8; i++) begin
        bit_slot(!rd, lsb_first ? b[i] : b[7-i], got);
        if (lsb_first) begin
          rdata[16-8*k+i] = got;
        end else begin
          rdata[23-8*k-i] = got;
        end
      end
    end
    wait_clk(HALF);
    o_cs_n = 1'b1;
    o_sdio_oe = 1'b0;
    wait_clk(HALF);
  endtask
endmodule // sscrm_host_model

// ==== tb/sscrm_regmap_tb.sv ====
`timescale 1ns/1ps
module sscrm_regmap_tb;
  localparam logic [7:0] TB_CHIP_ID = 8'h3C; // Arbitrary identity value.
  localparam int LIMIT = 80000;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic sclk, cs_n, host_sdio, host_oe, dut_sdio, dut_oe, sdio_line;
  sscrm_pkg::sscrm_chan_cfg_type act_a, act_b;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [23:0] rbuf;

  // ----------------------------------------------------------------------
  // Clock, wire and instances
  // ----------------------------------------------------------------------
  // 40 MHz reference clock.
  always #12.5 ref_clk = ~ref_clk;

  // Both drivers on at once show as unknown, so a fight fails a read.
  assign sdio_line = dut_oe ? (host_oe ? 1'bx : dut_sdio) : host_sdio;

  sscrm_regmap #(.CHIP_ID(TB_CHIP_ID), .CHIP_GRADE(8'h00)) u_dut (
    .i_ref_clk(ref_clk),
    .i_srst(srst),
    .i_spi_sclk(sclk),
    .i_spi_cs_n(cs_n),
    .i_spi_sdio(sdio_line),
    .o_spi_sdio(dut_sdio),
    .o_spi_sdio_oe(dut_oe),
    .o_active_a(act_a),
    .o_active_b(act_b)
  );

  sscrm_host_model u_host (
    .i_ref_clk(ref_clk),
    .i_sdio(sdio_line),
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_sdio(host_sdio),
    .o_sdio_oe(host_oe)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t read %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_act(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t active %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    u_host.frame(1'b0, 2'h0, a, {d, 16'h0000}, rbuf);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    u_host.frame(1'b1, 2'h0, a, 24'h000000, rbuf);
    chk_reg({8'h00, rbuf[23:16]}, {8'h00, exp}, "byte");
  endtask

  // Reset held for 16 cycles, then the synchronisers settle to idle.
  task automatic do_reset();
    srst = 1'b1;
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask

  // A hang is cut short here and counted as a mismatch.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk(13'h0018, 8'hC0);
    chk_act(act_a.conv[16], 8'hC0, "a vref");
    chk_act(act_b.conv[16], 8'hC0, "b vref");
    rd_chk(13'h0000, 8'h18);
    rd_chk(13'h0001, TB_CHIP_ID);
    rd_chk(13'h0005, 8'h03);
    rd_chk(13'h0003, 8'h00);
    rd_chk(13'h0123, 8'h00);
    $display("test reset_defaults done");

    // Shadowed writes stay hidden until the transfer command.
    wr(13'h0005, 8'h01);
    wr(13'h000A, 8'h55);
    chk_act(act_a.conv[2], 8'h00, "a conv2 held");
    rd_chk(13'h000A, 8'h55);
    wr(13'h011E, 8'hA7);
    chk_act(act_a.feat[30], 8'h00, "a feat30 held");
    wr(13'h011D, 8'h3C);
    chk_act(act_a.feat[29], 8'h3C, "a feat29 direct");
    wr(13'h00FF, 8'h02);
    chk_act(act_a.conv[2], 8'h00, "a conv2 no xfer");
    wr(13'h00FF, 8'h01);
    chk_act(act_a.conv[2], 8'h55, "a conv2 xfer");
    chk_act(act_a.feat[30], 8'hA7, "a feat30 xfer");
    chk_act(act_b.conv[2], 8'h00, "b conv2");
    rd_chk(13'h00FF, 8'h00);
    rd_chk(13'h000A, 8'h55);
    $display("test shadow_transfer done");

    // Per-channel copies, both-selected write and read.
    wr(13'h0005, 8'h03);
    wr(13'h000C, 8'h5A);
    wr(13'h0005, 8'h02);
    wr(13'h000C, 8'h69);
    wr(13'h00FF, 8'h01);
    chk_act(act_a.conv[4], 8'h5A, "a conv4");
    chk_act(act_b.conv[4], 8'h69, "b conv4");
    rd_chk(13'h000C, 8'h69);
    rd_chk(13'h0005, 8'h02);
    rd_chk(13'h0000, 8'h18);
    rd_chk(13'h0001, TB_CHIP_ID);
    wr(13'h0005, 8'h03);
    rd_chk(13'h000C, 8'h5A);
    $display("test channels done");

    // Two-byte frames walk the address downward in MSB-first order.
    u_host.frame(1'b0, 2'h1, 13'h000B, 24'h112200, rbuf);
    rd_chk(13'h000A, 8'h22);
    u_host.frame(1'b1, 2'h1, 13'h000B, 24'h000000, rbuf);
    chk_reg(rbuf[23:8], 16'h1122, "two bytes");
    $display("test multi_byte done");

    // Bit order switch, then a full-byte value through the shadow.
    wr(13'h0000, 8'h42);
    u_host.lsb_first = 1'b1;
    rd_chk(13'h0000, 8'h5A);
    wr(13'h0018, 8'h80);
    rd_chk(13'h0018, 8'h80);
    wr(13'h00FF, 8'h01);
    chk_act(act_a.conv[16], 8'h80, "a vref lsb");
    // An LSB-first stream walks the address upward until CS goes high.
    u_host.frame(1'b0, 2'h3, 13'h0100, 24'h0A0B0C, rbuf);
    chk_act(act_a.feat[2], 8'h0C, "a feat2 stream");
    chk_act(act_b.feat[0], 8'h0A, "b feat0 stream");
    u_host.frame(1'b1, 2'h2, 13'h0100, 24'h000000, rbuf);
    chk_reg(rbuf[15:0], 16'h0B0C, "three bytes lsb");
    $display("test bit_order done");

    // A second reset restores every default.
    do_reset();
    u_host.lsb_first = 1'b0;
    rd_chk(13'h0000, 8'h18);
    rd_chk(13'h0018, 8'hC0);
    rd_chk(13'h000A, 8'h00);
    chk_act(act_a.conv[16], 8'hC0, "a vref rst");
    chk_act(act_a.feat[29], 8'h00, "a feat29 rst");
    chk_act(act_b.conv[4], 8'h00, "b conv4 rst");
    $display("test second_reset done");
    final_report();
  end
endmodule // sscrm_regmap_tb
